// ### hw/odc_cmd_port.sv
`timescale 1ns/1ps
module odc_cmd_port #(
  parameter bit TWO_STRAP = 1'b1,
  parameter int DATA_BITS = 12
) (
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe,
  input  wire logic                     strap0,
  input  wire logic                     strap0_float,
  input  wire logic                     strap1,
  input  wire logic                     strap1_float,
  input  wire logic [15:0]              rd_data,
  output logic                          upd_valid,
  output odc_pkg::odc_upd_type          upd,
  output logic [DATA_BITS-1:0]          upd_code,
  output logic [7:0]                    command_access_byte,
  output odc_pkg::odc_dec_type          ca_dec
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {PH_IDLE, PH_RX, PH_RX_ACK, PH_TX, PH_TX_ACK, PH_IGNORE} odc_phase_type;
  typedef enum logic [1:0] {RO_ADDR, RO_CA, RO_HIGH, RO_LOW} odc_role_type;

  typedef struct packed {
    odc_phase_type        phase;
    odc_role_type         role;
    logic [3:0]           cnt;
    logic [7:0]           shift;
    logic                 rw;
    logic [7:0]           ca;
    odc_pkg::odc_dec_type dec;
    logic                 ca_valid;
    logic [7:0]           high;
    logic [15:0]          txbuf;
    logic                 mack;
    logic                 scl_q;
    logic                 sda_q;
    logic                 oe;
    logic                 upd_valid;
    odc_pkg::odc_upd_type upd;
  } odc_state_type;

  localparam odc_state_type STATE_RESET = '{
    phase: PH_IDLE, role: RO_ADDR, cnt: 4'h0, shift: 8'h00, rw: 1'b0, ca: 8'h00,
    dec: '{op: odc_pkg::OP_INVALID, rsel: odc_pkg::RD_INVALID, mask: 8'h00},
    ca_valid: 1'b0, high: 8'h00, txbuf: 16'h0000, mack: 1'b0, scl_q: 1'b1, sda_q: 1'b1,
    oe: 1'b0, upd_valid: 1'b0,
    upd: '{op: odc_pkg::OP_INVALID, mask: 8'h00, data: 16'h0000}
  };

  odc_state_type        st_reg;
  odc_state_type        st_next;
  odc_pkg::odc_pins_type pins;
  logic [5:0]           pins_q;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  odc_pin_sync #(
    .W    (6),
    .INIT (odc_pkg::SYNC_INIT)
  ) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .d        ({strap1_float, strap1, strap0_float, strap0, sda_in, scl_in}),
    .q        (pins_q)
  );

  assign pins = odc_pkg::odc_pins_type'(pins_q);

  // ----------------------------------------
  // Decoding functions
  // ----------------------------------------
  function automatic logic [3:0] strap_addr(input odc_pkg::odc_pins_type p);
    logic [3:0] r;
    r = 4'h0;
    if (TWO_STRAP) begin
      if (p.strap1_float && p.strap0_float) begin
        r = 4'h0;
      end else if (p.strap1_float) begin
        r = {1'b1, 2'b10, p.strap0};
      end else if (p.strap0_float) begin
        r = {1'b1, 2'b11, p.strap1};
      end else begin
        r = {1'b1, 1'b0, p.strap1, p.strap0};
      end
    end else begin
      if (p.strap0_float) begin
        r = 4'hC;
      end else if (p.strap0) begin
        r = 4'hA;
      end else begin
        r = 4'h8;
      end
    end
    return r;
  endfunction

  function automatic odc_pkg::odc_dec_type decode_ca(input logic [7:0] b);
    odc_pkg::odc_dec_type d;
    logic [3:0]           cmd;
    logic [3:0]           acc;
    cmd = b[7:4];
    acc = b[3:0];
    d.op   = odc_pkg::OP_INVALID;
    d.rsel = odc_pkg::RD_INVALID;
    d.mask = 8'h00;
    if (acc == odc_pkg::ACCESS_ALL) begin
      d.mask = 8'hFF;
    end else if (!acc[3]) begin
      d.mask = 8'(8'h01 << acc[2:0]);
    end
    unique case (cmd)
      odc_pkg::CMD_WR_IN:      d.op = odc_pkg::OP_WR_IN;
      odc_pkg::CMD_UPD:        d.op = odc_pkg::OP_UPD;
      odc_pkg::CMD_WR_UPD_ALL: d.op = odc_pkg::OP_WR_UPD_ALL;
      odc_pkg::CMD_WR_UPD:     d.op = odc_pkg::OP_WR_UPD;
      odc_pkg::CMD_POWER:      d.op = odc_pkg::OP_POWER;
      odc_pkg::CMD_CLEAR:      d.op = odc_pkg::OP_CLEAR;
      odc_pkg::CMD_LOADCTL:    d.op = odc_pkg::OP_LOADCTL;
      odc_pkg::CMD_RESET:      d.op = odc_pkg::OP_RESET;
      default:                 d.op = odc_pkg::OP_INVALID;
    endcase
    unique case (cmd)
      odc_pkg::CMD_WR_IN:   d.rsel = odc_pkg::RD_IN;
      odc_pkg::CMD_UPD:     d.rsel = odc_pkg::RD_OUT;
      odc_pkg::CMD_POWER:   d.rsel = odc_pkg::RD_POWER;
      odc_pkg::CMD_CLEAR:   d.rsel = odc_pkg::RD_CLEAR;
      odc_pkg::CMD_LOADCTL: d.rsel = odc_pkg::RD_LOADCTL;
      default:              d.rsel = odc_pkg::RD_INVALID;
    endcase
    if (!cmd[2] && d.mask == 8'h00) begin
      d.op   = odc_pkg::OP_INVALID;
      d.rsel = odc_pkg::RD_INVALID;
    end
    if (cmd[2]) begin
      d.mask = 8'h00;
    end
    return d;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic       ack;
    logic [3:0] sa;
    rise  = pins.scl & ~st_reg.scl_q;
    fall  = ~pins.scl & st_reg.scl_q;
    start = st_reg.scl_q & pins.scl & st_reg.sda_q & ~pins.sda;
    stop  = st_reg.scl_q & pins.scl & ~st_reg.sda_q & pins.sda;
    sa    = strap_addr(pins);
    ack   = 1'b0;
    st_next           = st_reg;
    st_next.scl_q     = pins.scl;
    st_next.sda_q     = pins.sda;
    st_next.upd_valid = 1'b0;
    if (start) begin
      st_next.phase = PH_RX;
      st_next.role  = RO_ADDR;
      st_next.cnt   = 4'h0;
      st_next.oe    = 1'b0;
    end else if (stop) begin
      st_next.phase    = PH_IDLE;
      st_next.oe       = 1'b0;
      st_next.ca_valid = 1'b0;
    end else begin
      unique case (st_reg.phase)
        PH_IDLE, PH_IGNORE: begin
          st_next.oe = 1'b0;
        end
        PH_RX: begin
          if (rise) begin
            st_next.shift = {st_reg.shift[6:0], pins.sda};
            st_next.cnt   = 4'(st_reg.cnt + 4'h1);
          end else if (fall && st_reg.cnt == odc_pkg::BITS_PER_BYTE) begin
            if (st_reg.role == RO_ADDR) begin
              ack = (st_reg.shift[7:4] == odc_pkg::ADDR_PREFIX && sa[3] &&
                     st_reg.shift[3:1] == sa[2:0]) ||
                    (st_reg.shift[7:1] == odc_pkg::BCAST_ADDR && !st_reg.shift[0]);
              st_next.rw = st_reg.shift[0];
            end else begin
              ack = 1'b1;
            end
            st_next.phase = ack ? PH_RX_ACK : PH_IGNORE;
            st_next.oe    = ack;
          end
        end
        PH_RX_ACK: begin
          if (fall) begin
            st_next.oe    = 1'b0;
            st_next.cnt   = 4'h0;
            st_next.phase = PH_RX;
            unique case (st_reg.role)
              RO_ADDR: begin
                if (st_reg.rw) begin
                  st_next.phase = PH_TX;
                  st_next.role  = RO_HIGH;
                  st_next.txbuf = rd_data;
                  st_next.oe    = ~rd_data[15];
                end else begin
                  st_next.role = RO_CA;
                end
              end
              RO_CA: begin
                st_next.ca       = st_reg.shift;
                st_next.dec      = decode_ca(st_reg.shift);
                st_next.ca_valid = 1'b1;
                st_next.role     = RO_HIGH;
              end
              RO_HIGH: begin
                st_next.high = st_reg.shift;
                st_next.role = RO_LOW;
              end
              RO_LOW: begin
                st_next.upd_valid = st_reg.ca_valid;
                st_next.upd.op    = st_reg.dec.op;
                st_next.upd.mask  = st_reg.dec.mask;
                st_next.upd.data  = {st_reg.high, st_reg.shift};
                st_next.role      = RO_HIGH;
              end
            endcase
          end
        end
        PH_TX: begin
          if (fall) begin
            st_next.txbuf = {st_reg.txbuf[14:0], 1'b0};
            if (st_reg.cnt == odc_pkg::TX_LAST_BIT) begin
              st_next.oe    = 1'b0;
              st_next.phase = PH_TX_ACK;
            end else begin
              st_next.cnt = 4'(st_reg.cnt + 4'h1);
              st_next.oe  = ~st_reg.txbuf[14];
            end
          end
        end
        PH_TX_ACK: begin
          if (rise) begin
            st_next.mack = ~pins.sda;
          end else if (fall) begin
            st_next.cnt = 4'h0;
            if (!st_reg.mack) begin
              st_next.phase = PH_IGNORE;
            end else if (st_reg.role == RO_HIGH) begin
              st_next.phase = PH_TX;
              st_next.role  = RO_LOW;
              st_next.oe    = ~st_reg.txbuf[15];
            end else begin
              st_next.phase = PH_TX;
              st_next.role  = RO_HIGH;
              st_next.txbuf = rd_data;
              st_next.oe    = ~rd_data[15];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sda_out             = 1'b0;
  assign sda_oe              = st_reg.oe;
  assign upd_valid           = st_reg.upd_valid;
  assign upd                 = st_reg.upd;
  assign upd_code            = st_reg.upd.data[15 -: DATA_BITS];
  assign command_access_byte = st_reg.ca;
  assign ca_dec              = st_reg.dec;

endmodule

// ### hw/odc_pkg.sv
// Summary of operation
// - Acknowledge a matching address and each byte after it; 36 clocks for first update.
// - Apply update at falling edge after low-byte acknowledge.
// - Last command byte repeats for further data pairs.
// - Repeated update takes exactly 18 bus clocks.
// - Stop releases bus, drops command, awaits start.
// - Address prefix 1001, least bit is direction.
// - Three address bits from straps, resampled each time.
// - Two-strap table maps pin pairs to addresses.
// - Single strap gives 000, 010 or 100.
// - Split command byte into command and access nibbles.
// - Channel write commands 0000 to 0011 decoded.
// - Commands 0100 to 0111 ignore access nibble.
// - Read commands choose which register returns.
// - Access 0000-0111 selects channel, 1111 all.
// - High byte is bits 15:8, MSB first.
// - Data left-justified, unused low bits ignored.
// - Broadcast address 1000111 answered for writes only.
// - Read: write command, repeated start, two bytes back.
package odc_pkg;

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam logic [3:0] ADDR_PREFIX   = 4'h9;
  localparam logic [6:0] BCAST_ADDR    = 7'h47;
  localparam logic [3:0] ACCESS_ALL    = 4'hF;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] TX_LAST_BIT   = 4'h7;
  localparam logic [5:0] SYNC_INIT     = 6'h03;
  localparam logic [3:0] CMD_WR_IN     = 4'h0;
  localparam logic [3:0] CMD_UPD       = 4'h1;
  localparam logic [3:0] CMD_WR_UPD_ALL = 4'h2;
  localparam logic [3:0] CMD_WR_UPD    = 4'h3;
  localparam logic [3:0] CMD_POWER     = 4'h4;
  localparam logic [3:0] CMD_CLEAR     = 4'h5;
  localparam logic [3:0] CMD_LOADCTL   = 4'h6;
  localparam logic [3:0] CMD_RESET     = 4'h7;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_WR_IN, OP_UPD, OP_WR_UPD_ALL, OP_WR_UPD, OP_POWER,
    OP_CLEAR, OP_LOADCTL, OP_RESET, OP_INVALID
  } odc_op_type;

  typedef enum logic [2:0] {
    RD_IN, RD_OUT, RD_POWER, RD_CLEAR, RD_LOADCTL, RD_INVALID
  } odc_rsel_type;

  typedef struct packed {
    odc_op_type   op;
    odc_rsel_type rsel;
    logic [7:0]   mask;
  } odc_dec_type;

  typedef struct packed {
    odc_op_type op;
    logic [7:0] mask;
    logic [15:0] data;
  } odc_upd_type;

  typedef struct packed {
    logic strap1_float;
    logic strap1;
    logic strap0_float;
    logic strap0;
    logic sda;
    logic scl;
  } odc_pins_type;

endpackage

// ### hw/odc_pin_sync.sv
`timescale 1ns/1ps
module odc_pin_sync #(
  parameter int         W    = 6,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] ff1_reg;
  logic [W-1:0] ff2_reg;
  logic [W-1:0] ff3_reg;

  // ----------------------------------------
  // Three stages, change taken when two agree
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ff1_reg <= INIT;
      ff2_reg <= INIT;
      ff3_reg <= INIT;
      q       <= INIT;
    end else begin
      ff1_reg <= d;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      for (int i = 0; i < W; i++) begin
        if (ff2_reg[i] == ff3_reg[i]) begin
          q[i] <= ff3_reg[i];
        end
      end
    end
  end

endmodule

// ### testbench/odc_cmd_port_properties.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module odc_cmd_port_properties #(
  parameter bit TWO_STRAP = 1'b1,
  parameter int DATA_BITS = 12
) (
  input wire logic                 core_clk,
  input wire logic                 resetn,
  input wire logic                 scl_in,
  input wire logic                 sda_in,
  input wire logic                 sda_out,
  input wire logic                 sda_oe,
  input wire logic                 strap0,
  input wire logic                 strap0_float,
  input wire logic                 strap1,
  input wire logic                 strap1_float,
  input wire logic [15:0]          rd_data,
  input wire logic                 upd_valid,
  input wire odc_pkg::odc_upd_type upd,
  input wire logic [DATA_BITS-1:0] upd_code,
  input wire logic [7:0]           command_access_byte,
  input wire odc_pkg::odc_dec_type ca_dec
);
  wire [3:0] cmd = command_access_byte[7:4];
  wire [3:0] acc = command_access_byte[3:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_out_low: assert property (sda_out == 1'b0) else $error("sda_out not low");
  a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved in clock high");
  a_upd_single: assert property (upd_valid |=> !upd_valid) else $error("update pulse too long");
  a_upd_at_ack: assert property (upd_valid |-> $fell(sda_oe)) else $error("update off ack fall");
  a_upd_held: assert property (!upd_valid |-> $stable(upd)) else $error("update moved alone");
  a_code_slice: assert property (upd_valid |-> upd_code == upd.data[15 -: DATA_BITS])
    else $error("code not left justified");
  a_chan_mask: assert property ($stable(command_access_byte) && ca_dec.op != odc_pkg::OP_INVALID
    && cmd <= 4'h3 && acc <= 4'h7 |-> ca_dec.mask == (8'h01 << acc)) else $error("channel mask");
  a_all_mask: assert property ($stable(command_access_byte) && ca_dec.op != odc_pkg::OP_INVALID
    && cmd <= 4'h3 && acc == 4'hF |-> ca_dec.mask == 8'hFF) else $error("all mask");
  a_op_decode: assert property ($stable(command_access_byte) && cmd != 4'h0 && cmd <= 4'h7
    && (cmd >= 4'h4 || acc <= 4'h7 || acc == 4'hF) |-> ca_dec.op == odc_pkg::odc_op_type'(cmd))
    else $error("command decode");
  c_update: cover property (upd_valid);
  c_all: cover property (ca_dec.mask == 8'hFF);
  c_drive: cover property ($rose(sda_oe));
endmodule
bind odc_cmd_port odc_cmd_port_properties #(.TWO_STRAP(TWO_STRAP), .DATA_BITS(DATA_BITS)) u_props (
  .core_clk(core_clk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .strap0(strap0), .strap0_float(strap0_float), .strap1(strap1),
  .strap1_float(strap1_float), .rd_data(rd_data), .upd_valid(upd_valid), .upd(upd),
  .upd_code(upd_code), .command_access_byte(command_access_byte), .ca_dec(ca_dec));

// ### testbench/odc_master_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bus master model
// ----------------------------------------
module odc_master_model (
  input  wire logic core_clk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One clock: data set in low phase, held through high phase
  task automatic put_bit(input logic b, output logic seen);
    wait_clk(3);
    sda_drv <= b;
    wait_clk(4);
    scl <= 1'b1;
    wait_clk(5);
    @(negedge core_clk) seen = sda_wire;
    @(posedge core_clk) scl <= 1'b0;
  endtask
  task automatic start();
    wait_clk(3);
    sda_drv <= 1'b1;
    wait_clk(4);
    scl <= 1'b1;
    wait_clk(3);
    sda_drv <= 1'b0;
    wait_clk(3);
    scl <= 1'b0;
  endtask
  task automatic stop();
    wait_clk(3);
    sda_drv <= 1'b0;
    wait_clk(4);
    scl <= 1'b1;
    wait_clk(3);
    sda_drv <= 1'b1;
    wait_clk(6);
  endtask
  // Eight bits MSB first, then the ninth clock
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic recv_byte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, b[i]);
    put_bit(!mack, s);
  endtask
endmodule

// ### testbench/odc_cmd_port_bench.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bench
// ----------------------------------------
module odc_cmd_port_bench;
  logic                 core_clk, resetn, strap0, strap0_float, strap1, strap1_float;
  logic                 scl, sda_drv, sda_out, sda_oe, upd_valid, scl_q, ack;
  logic                 one_sda_out, one_sda_oe, one_strap0, one_strap0_float;
  logic [15:0]          rd_data;
  logic [11:0]          upd_code;
  logic [7:0]           command_access_byte, rb;
  odc_pkg::odc_upd_type upd;
  odc_pkg::odc_dec_type ca_dec;
  int                   err_count = 0, n_compared = 0, cycles = 0, scl_rises = 0, gap_base = 0;
  int                   last_gap = 0, upd_count = 0;
  wire                  sda_wire = sda_drv & ~(sda_oe & ~sda_out) & ~(one_sda_oe & ~one_sda_out);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  odc_cmd_port #(.TWO_STRAP(1'b1), .DATA_BITS(12)) DUT (
    .core_clk(core_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe(sda_oe), .strap0(strap0), .strap0_float(strap0_float), .strap1(strap1),
    .strap1_float(strap1_float), .rd_data(rd_data), .upd_valid(upd_valid), .upd(upd),
    .upd_code(upd_code), .command_access_byte(command_access_byte), .ca_dec(ca_dec));
  // Single-strap device on the same bus
  odc_cmd_port #(.TWO_STRAP(1'b0), .DATA_BITS(12)) DUT_ONE (
    .core_clk(core_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_wire), .sda_out(one_sda_out),
    .sda_oe(one_sda_oe), .strap0(one_strap0), .strap0_float(one_strap0_float), .strap1(1'b0),
    .strap1_float(1'b0), .rd_data(16'h0000), .upd_valid(), .upd(), .upd_code(),
    .command_access_byte(), .ca_dec());
  odc_master_model M (.core_clk(core_clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Bus clock and update monitor
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    scl_q <= scl;
    if (scl && !scl_q) scl_rises <= scl_rises + 1;
    if (upd_valid === 1'b1) begin
      upd_count <= upd_count + 1;
      last_gap <= scl_rises - gap_base;
      gap_base <= scl_rises;
    end
    if (cycles == 30000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic t_straps();
    logic [3:0] st [10] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'h2, 4'h6, 4'hA, 4'h0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk) {strap1_float, strap1, strap0_float, strap0} <= st[i];
      M.start();
      M.send_byte({4'h9, (i == 9) ? 3'h1 : 3'(i), 1'b0}, ack);
      M.stop();
      check("addr_ack", 16'(ack), 16'(i < 8));
    end
    $display("t_straps done");
  endtask
  task automatic t_commands();
    logic [3:0] acc;
    for (int c = 0; c < 9; c++) begin
      acc = (c == 0) ? 4'hF : 4'(c % 8);
      M.start();
      M.send_byte(8'h90, ack);
      M.send_byte({4'(c), acc}, ack);
      repeat (8) @(posedge core_clk);
      check("ca_ack", 16'(ack), 16'h0001);
      check("ca_byte", 16'(command_access_byte), 16'({4'(c), acc}));
      check("ca_op", 16'(ca_dec.op), (c == 8) ? 16'(odc_pkg::OP_INVALID) : 16'(c));
      if (c < 4) check("ca_mask", 16'(ca_dec.mask), (c == 0) ? 16'h00FF : 16'(8'h01 << acc));
      if (c < 2 || (c > 3 && c < 7)) check("ca_rsel", 16'(ca_dec.rsel), 16'(c < 2 ? c : c - 2));
    end
    M.stop();
    $display("t_commands done");
  endtask
  task automatic t_write();
    int n0 = upd_count;
    M.start();
    M.send_byte(8'h90, ack);
    M.send_byte(8'h31, ack);
    M.send_byte(8'hAB, ack);
    M.send_byte(8'hCD, ack);
    repeat (8) @(posedge core_clk);
    check("low_ack", 16'(ack), 16'h0001);
    check("upd_count", 16'(upd_count), 16'(n0 + 1));
    check("upd_data", upd.data, 16'hABCD);
    check("upd_op", 16'(upd.op), 16'(odc_pkg::OP_WR_UPD));
    check("upd_mask", 16'(upd.mask), 16'h0002);
    check("upd_code", 16'(upd_code), 16'h0ABC);
    M.send_byte(8'h12, ack);
    M.send_byte(8'h34, ack);
    repeat (8) @(posedge core_clk);
    check("upd_repeat", upd.data, 16'h1234);
    check("upd_gap", 16'(last_gap), 16'd18);
    M.send_byte(8'h55, ack);
    M.stop();
    repeat (8) @(posedge core_clk);
    check("lone_high", 16'(upd_count), 16'(n0 + 2));
    check("released", 16'(sda_oe), 16'h0000);
    $display("t_write done");
  endtask
  task automatic t_read();
    @(posedge core_clk) rd_data <= 16'h5A3C;
    M.start();
    M.send_byte(8'h90, ack);
    M.send_byte(8'h10, ack);
    M.start();
    M.send_byte(8'h91, ack);
    check("rd_addr_ack", 16'(ack), 16'h0001);
    M.recv_byte(1'b1, rb);
    check("rd_high", 16'(rb), 16'h005A);
    M.recv_byte(1'b0, rb);
    check("rd_low", 16'(rb), 16'h003C);
    M.stop();
    $display("t_read done");
  endtask
  task automatic t_bcast();
    int n0 = upd_count;
    @(posedge core_clk) {strap1_float, strap1, strap0_float, strap0} <= 4'hA;
    M.start();
    M.send_byte(8'h8E, ack);
    check("bc_ack", 16'(ack), 16'h0001);
    M.send_byte(8'h40, ack);
    M.send_byte(8'h00, ack);
    M.send_byte(8'h00, ack);
    repeat (8) @(posedge core_clk);
    check("bc_upd", 16'(upd_count), 16'(n0 + 1));
    check("bc_op", 16'(upd.op), 16'(odc_pkg::OP_POWER));
    M.start();
    M.send_byte(8'h8F, ack);
    check("bc_rd_ack", 16'(ack), 16'h0000);
    M.send_byte(8'h00, ack);
    check("ignored_ack", 16'(ack), 16'h0000);
    M.stop();
    $display("t_bcast done");
  endtask
  task automatic t_single();
    logic [1:0] st [4] = '{2'b00, 2'b01, 2'b10, 2'b00};
    logic [2:0] ad [4] = '{3'h0, 3'h2, 3'h4, 3'h2};
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk) {one_strap0_float, one_strap0} <= st[i];
      M.start();
      M.send_byte({4'h9, ad[i], 1'b0}, ack);
      M.stop();
      check("one_ack", 16'(ack), 16'(i < 3));
    end
    $display("t_single done");
  endtask
  initial begin
    resetn = 1'b0;
    {strap1_float, strap1, strap0_float, strap0} = 4'h0;
    {one_strap0_float, one_strap0} = 2'b01;
    rd_data = 16'h0000;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_straps();
    t_commands();
    t_write();
    t_read();
    t_bcast();
    t_single();
    give_verdict();
  end
endmodule
